// [common/card_window_cfg.svh]
// constants for the card window mapper: layout, reset values and timing
`ifndef CARD_WINDOW_CFG_SVH
`define CARD_WINDOW_CFG_SVH

// window counts and register file layout
`define MW_COUNT        10
`define MW_PER_SOCK     5
`define MW_REGS         6
`define IW_COUNT        4
`define IW_PER_SOCK     2
`define IW_REGS         4
`define IW_BASE         60
`define PAGE_BASE       76
`define CFG_BYTES       78
`define CFG_AW          7
`define CFG_RESET_VAL   8'h00

// memory window byte offsets inside one window
`define MW_START_LO     0
`define MW_START_HI     1
`define MW_END_LO       2
`define MW_END_HI       3
`define MW_OFF_LO       4
`define MW_OFF_HI       5

// memory window field positions
`define MW_WIDE_BIT     7
`define MW_WS_LSB       6
`define MW_ATTR_BIT     6
`define MW_EN_BIT       7
`define MW_MIN_PAGE     12'h0010

// i/o window byte offsets and control field positions
`define IW_START_LO     0
`define IW_START_HI     1
`define IW_END_LO       2
`define IW_END_HI       3
`define IC_EN_BIT       0
`define IC_WIDE_BIT     1
`define IC_WS_LSB       2

// interrupt terminals and route code for no route
`define IRQ_COUNT       10
`define ROUTE_OFF       4'h0

// timing: system clock period, legacy bus clock period, strobe length
`define CLK_PERIOD_PS   4000
`define AT_PERIOD_PS    120000
`define AT_CYCLES       ((`AT_PERIOD_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CARD_BASE_AT    2
`define CARD_NARROW_AT  1

`endif

// [common/card_window_pkg.sv]
// types shared by the card window mapper files
package card_window_pkg;
    `include "card_window_cfg.svh"

    typedef logic [`CFG_BYTES-1:0][7:0] cfg_bytes_t;

    typedef enum logic [3:0] {
        S_IDLE   = 4'b0001,
        S_SETUP  = 4'b0010,
        S_STROBE = 4'b0100,
        S_HOLD   = 4'b1000
    } cyc_state_t;

    typedef struct packed {
        logic [25:0] addr;
        logic [15:0] wdata;
        logic        ce1_n;
        logic        ce2_n;
        logic        oe_n;
        logic        we_n;
        logic        iord_n;
        logic        iowr_n;
        logic        reg_n;
        logic        reset;
    } card_pins_t;

    typedef struct packed {
        logic rdy_bsy;
        logic bvd1;
        logic bvd2;
        logic cd1_n;
        logic cd2_n;
        logic wait_n;
    } card_sts_t;

    typedef struct packed {
        logic        is_io;
        logic        write;
        logic [31:0] addr;
        logic [15:0] wdata;
    } host_req_t;
endpackage

// [design/window_store.sv]
// register storage for all window, offset and page bytes
`timescale 1ns/1ps
`default_nettype none
`include "card_window_cfg.svh"
module window_store (
    // clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      reset,
    // byte access port
    input  wire logic                      we,
    input  wire logic [`CFG_AW-1:0]        addr,
    input  wire logic [7:0]                wdata,
    output logic      [7:0]                rdata,
    // all bytes for parallel decode
    output card_window_pkg::cfg_bytes_t    regs
);
    import card_window_pkg::*;

    typedef struct packed {
        cfg_bytes_t bytes;
        logic [7:0] rdata;
    } store_t;

    store_t st_r;
    store_t st_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // write and registered read; unmapped bytes read as zero
    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = 8'h00;
        if (addr < `CFG_AW'(`CFG_BYTES)) begin
            st_nxt.rdata = st_r.bytes[addr];
            if (we) begin
                st_nxt.bytes[addr] = wdata;
            end
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_r <= '{bytes: {`CFG_BYTES{`CFG_RESET_VAL}}, rdata: 8'h00};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rdata;
    assign regs  = st_r.bytes;
endmodule
`default_nettype wire

// [design/card_window_mapper.sv]
// card window decode, translation, cycle timing and interrupt routing
// Function
// - power_down_bit high places the device in power-down.
// - power-down releases every card output and bidirectional of both sockets.
// - registers keep values and stay readable and writable in power-down.
// - card and status-change interrupts keep working in power-down.
// - window hits are answered in power-down but run no card cycle.
// - wait-state bits lengthen strobes in legacy 8.33 MHz bus clock steps.
// - ten memory windows, five for each socket.
// - memory windows sit on 4K boundaries, only above the lowest 64K.
// - each memory window selects 16-bit or 8-bit card width.
// - each memory window selects attribute or common space via register select.
// - each memory window owns six configuration bytes.
// - start and end compare host bits 23..12; offset covers card bits 25..12.
// - per-socket page byte must equal host bits 31..24 to enable decode.
// - card address is host address plus offset, wrapping in 26 bits.
// - four i/o windows, two for each socket.
// - i/o windows are byte granular in lowest 64K, 16 or 8 bit.
// - each i/o window owns four bytes; start and end compare bits 15..0.
// - input-acknowledge plays no part in i/o decode.
// - ten host interrupt terminals, open-drain or rising-edge push-pull.
// - ready/busy low on an i/o card is a host interrupt source.
// - ready/busy (memory cards only), battery detect or card detect changes raise status change.
`timescale 1ns/1ps
`default_nettype none
`include "card_window_cfg.svh"
module card_window_mapper (
    // clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          reset,
    // configuration
    input  wire logic                          power_down_bit,
    input  wire logic                          cfg_we,
    input  wire logic [`CFG_AW-1:0]            cfg_addr,
    input  wire logic [7:0]                    cfg_wdata,
    output logic      [7:0]                    cfg_rdata,
    input  wire logic [`IW_COUNT-1:0][3:0]     io_ctrl,
    // host requests and answers
    input  wire logic                          req_valid,
    input  wire card_window_pkg::host_req_t    req,
    output logic                               req_ready,
    output logic                               rsp_done,
    output logic                               rsp_hit,
    output logic      [15:0]                   rsp_rdata,
    // card sockets
    output card_window_pkg::card_pins_t [1:0]  card_pins,
    output logic      [1:0]                    card_pins_oe_n,
    output logic      [1:0]                    card_data_oe_n,
    input  wire logic [1:0][15:0]              card_data_in,
    input  wire card_window_pkg::card_sts_t [1:0] card_sts,
    input  wire logic [1:0]                    card_is_io,
    input  wire logic [1:0]                    card_reset_req,
    input  wire logic [1:0]                    card_inpack_n,
    // interrupt routing and status change
    input  wire logic [1:0][3:0]               irq_route,
    input  wire logic [1:0][3:0]               csc_route,
    input  wire logic [`IRQ_COUNT-1:0]         isa_mode,
    input  wire logic [1:0]                    csc_clear,
    input  wire logic [1:0]                    card_irq_clear,
    output logic      [1:0]                    csc_flag,
    output logic      [1:0]                    card_irq_flag,
    output logic      [`IRQ_COUNT-1:0]         irq_out,
    output logic      [`IRQ_COUNT-1:0]         irq_oe_n
);
    import card_window_pkg::*;

    typedef struct packed {
        cyc_state_t                     fsm;
        logic                           ready;
        logic                           sock;
        logic                           is_io;
        logic                           write;
        logic [7:0]                     cnt;
        logic [7:0]                     want;
        logic [7:0]                     strb_len;
        card_pins_t [1:0]               pins;
        logic [1:0]                     pins_oe_n;
        logic [1:0]                     data_oe_n;
        logic [15:0]                    rdata;
        logic                           rsp_done;
        logic                           rsp_hit;
        logic [1:0][4:0]                prev_sts;
        logic [1:0]                     csc_flag;
        logic [1:0]                     irq_flag;
        logic [`IRQ_COUNT-1:0]          irq_out;
        logic [`IRQ_COUNT-1:0]          irq_oe_n;
    } map_state_t;

    map_state_t st_r;
    map_state_t st_nxt;
    cfg_bytes_t regs;

    ////////////////////////////////////////////////////////////////////////////
    // register storage; no power-down gating on this port
    window_store u_store (
        .clk_sys (clk_sys),
        .reset   (reset),
        .we      (cfg_we),
        .addr    (cfg_addr),
        .wdata   (cfg_wdata),
        .rdata   (cfg_rdata),
        .regs    (regs)
    );

    ////////////////////////////////////////////////////////////////////////////
    // field helpers
    function automatic logic [7:0] mw_byte(cfg_bytes_t b, int unsigned w, int unsigned o);
        return b[w * `MW_REGS + o];
    endfunction

    function automatic logic [7:0] iw_byte(cfg_bytes_t b, int unsigned w, int unsigned o);
        return b[`IW_BASE + w * `IW_REGS + o];
    endfunction

    // strobe length in system clocks for a width and wait-state setting
    function automatic logic [7:0] strobe_cycles(logic wide, logic [1:0] ws);
        logic [7:0] steps;
        steps = 8'(`CARD_BASE_AT) + (wide ? 8'h00 : 8'(`CARD_NARROW_AT)) + {6'h00, ws};
        return 8'(steps * 8'(`AT_CYCLES));
    endfunction

    // legacy status signals of one socket packed for change detection
    function automatic logic [4:0] sts_vec(card_sts_t s);
        return {s.rdy_bsy, s.bvd1, s.bvd2, s.cd1_n, s.cd2_n};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next state: decode, card cycle sequencing, interrupts
    always_comb begin
        logic        found;
        logic        hsock;
        logic        hwide;
        logic        hattr;
        logic [1:0]  hws;
        logic [25:0] hcaddr;
        logic [11:0] page12;
        logic [11:0] wstart;
        logic [11:0] wend;
        logic [13:0] woff;
        logic [15:0] istart;
        logic [15:0] iend;
        logic [4:0]  cur;
        logic [1:0]  chg;
        logic [1:0]  irq_lvl;
        logic        act;
        found   = 1'b0;
        hsock   = 1'b0;
        hwide   = 1'b0;
        hattr   = 1'b0;
        hws     = 2'b00;
        hcaddr  = 26'h000_0000;
        page12  = req.addr[23:12];
        wstart  = 12'h000;
        wend    = 12'h000;
        woff    = 14'h0000;
        istart  = 16'h0000;
        iend    = 16'h0000;
        cur     = 5'h00;
        chg     = 2'b00;
        irq_lvl = 2'b00;
        act     = 1'b0;
        st_nxt  = st_r;
        st_nxt.rsp_done = 1'b0;

        // window decode; the loop order gives the lowest window priority
        if (!req.is_io) begin
            for (int w = 0; w < `MW_COUNT; w++) begin
                wstart = {regs[w * `MW_REGS + `MW_START_HI][3:0], mw_byte(regs, w, `MW_START_LO)};
                wend   = {regs[w * `MW_REGS + `MW_END_HI][3:0], mw_byte(regs, w, `MW_END_LO)};
                woff   = {regs[w * `MW_REGS + `MW_OFF_HI][5:0], mw_byte(regs, w, `MW_OFF_LO)};
                if (!found && regs[w * `MW_REGS + `MW_OFF_HI][`MW_EN_BIT]
                        && regs[`PAGE_BASE + w / `MW_PER_SOCK] == req.addr[31:24]
                        && page12 >= `MW_MIN_PAGE
                        && page12 >= wstart && page12 <= wend) begin
                    found  = 1'b1;
                    hsock  = (w >= `MW_PER_SOCK);
                    hwide  = regs[w * `MW_REGS + `MW_START_HI][`MW_WIDE_BIT];
                    hws    = regs[w * `MW_REGS + `MW_END_HI][`MW_WS_LSB +: 2];
                    hattr  = regs[w * `MW_REGS + `MW_OFF_HI][`MW_ATTR_BIT];
                    hcaddr = {14'({2'b00, page12} + woff), req.addr[11:0]};
                end
            end
        end else begin
            for (int w = 0; w < `IW_COUNT; w++) begin
                istart = {iw_byte(regs, w, `IW_START_HI), iw_byte(regs, w, `IW_START_LO)};
                iend   = {iw_byte(regs, w, `IW_END_HI), iw_byte(regs, w, `IW_END_LO)};
                // card_inpack_n is deliberately left out of this decode
                if (!found && io_ctrl[w][`IC_EN_BIT] && req.addr[31:16] == 16'h0000
                        && req.addr[15:0] >= istart && req.addr[15:0] <= iend) begin
                    found  = 1'b1;
                    hsock  = (w >= `IW_PER_SOCK);
                    hwide  = io_ctrl[w][`IC_WIDE_BIT];
                    hws    = io_ctrl[w][`IC_WS_LSB +: 2];
                    hcaddr = {10'h000, req.addr[15:0]};
                end
            end
        end

        // card cycle sequencer
        case (st_r.fsm)
            S_IDLE: begin
                if (req_valid) begin
                    st_nxt.rsp_hit = found;
                    if (!found || power_down_bit) begin
                        st_nxt.rsp_done = 1'b1;
                        st_nxt.rdata    = 16'h0000;
                    end else begin
                        st_nxt.sock  = hsock;
                        st_nxt.is_io = req.is_io;
                        st_nxt.write = req.write;
                        st_nxt.want  = strobe_cycles(hwide, hws);
                        st_nxt.pins[hsock].addr  = hcaddr;
                        st_nxt.pins[hsock].wdata = req.wdata;
                        st_nxt.pins[hsock].ce1_n = 1'b0;
                        st_nxt.pins[hsock].ce2_n = !hwide;
                        st_nxt.pins[hsock].reg_n = !(hattr && !req.is_io);
                        st_nxt.fsm = S_SETUP;
                    end
                end
            end
            S_SETUP: begin
                st_nxt.cnt      = st_r.want;
                st_nxt.strb_len = 8'h00;
                st_nxt.pins[st_r.sock].oe_n   = !(!st_r.is_io && !st_r.write);
                st_nxt.pins[st_r.sock].we_n   = !(!st_r.is_io && st_r.write);
                st_nxt.pins[st_r.sock].iord_n = !(st_r.is_io && !st_r.write);
                st_nxt.pins[st_r.sock].iowr_n = !(st_r.is_io && st_r.write);
                st_nxt.fsm = S_STROBE;
            end
            S_STROBE: begin
                st_nxt.strb_len = st_r.strb_len + 8'h01;
                if (st_r.cnt > 8'h01) begin
                    st_nxt.cnt = st_r.cnt - 8'h01;
                end else if (card_sts[st_r.sock].wait_n) begin
                    // the card may stretch the strobe further by holding wait low
                    st_nxt.rdata = card_data_in[st_r.sock];
                    st_nxt.pins[st_r.sock].oe_n   = 1'b1;
                    st_nxt.pins[st_r.sock].we_n   = 1'b1;
                    st_nxt.pins[st_r.sock].iord_n = 1'b1;
                    st_nxt.pins[st_r.sock].iowr_n = 1'b1;
                    st_nxt.fsm = S_HOLD;
                end
            end
            S_HOLD: begin
                st_nxt.pins[st_r.sock].ce1_n = 1'b1;
                st_nxt.pins[st_r.sock].ce2_n = 1'b1;
                st_nxt.pins[st_r.sock].reg_n = 1'b1;
                st_nxt.rsp_done = 1'b1;
                st_nxt.fsm      = S_IDLE;
            end
            default: begin
                st_nxt.fsm = S_IDLE;
            end
        endcase
        st_nxt.ready = (st_nxt.fsm == S_IDLE);

        // pin drivers; power-down releases everything at once
        for (int s = 0; s < 2; s++) begin
            st_nxt.pins[s].reset = card_reset_req[s];
            st_nxt.pins_oe_n[s]  = power_down_bit;
            st_nxt.data_oe_n[s]  = power_down_bit || !(st_nxt.write && st_nxt.sock == 1'(s)
                                   && (st_nxt.fsm == S_STROBE || st_nxt.fsm == S_HOLD));
        end

        // status change and card interrupt detection, never gated by power-down
        for (int s = 0; s < 2; s++) begin
            cur        = sts_vec(card_sts[s]);
            chg[s]     = ((cur[4] ^ st_r.prev_sts[s][4]) && !card_is_io[s])
                         || (cur[3:0] != st_r.prev_sts[s][3:0]);
            irq_lvl[s] = card_is_io[s] && !card_sts[s].rdy_bsy;
            st_nxt.prev_sts[s] = cur;
            // a new event in the clearing cycle keeps the flag set
            st_nxt.csc_flag[s] = chg[s] || (st_r.csc_flag[s] && !csc_clear[s]);
            st_nxt.irq_flag[s] = (irq_lvl[s] && st_r.prev_sts[s][4])
                                 || (st_r.irq_flag[s] && !card_irq_clear[s]);
        end

        // routing onto the host terminals
        for (int t = 0; t < `IRQ_COUNT; t++) begin
            act = 1'b0;
            for (int s = 0; s < 2; s++) begin
                if (irq_route[s] != `ROUTE_OFF && irq_route[s] == 4'(t + 1) && irq_lvl[s]) begin
                    act = 1'b1;
                end
                if (csc_route[s] != `ROUTE_OFF && csc_route[s] == 4'(t + 1)
                        && st_nxt.csc_flag[s]) begin
                    act = 1'b1;
                end
            end
            st_nxt.irq_out[t]  = isa_mode[t] ? act : 1'b0;
            st_nxt.irq_oe_n[t] = isa_mode[t] ? 1'b0 : !act;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_r           <= '0;
            st_r.fsm       <= S_IDLE;
            st_r.ready     <= 1'b1;
            st_r.pins      <= {2{26'h000_0000, 16'h0000, 8'b1111_1110}};
            st_r.pins_oe_n <= 2'b11;
            st_r.data_oe_n <= 2'b11;
            st_r.prev_sts  <= {2{5'h1F}};
            st_r.irq_oe_n  <= {`IRQ_COUNT{1'b1}};
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign req_ready      = st_r.ready;
    assign rsp_done       = st_r.rsp_done;
    assign rsp_hit        = st_r.rsp_hit;
    assign rsp_rdata      = st_r.rdata;
    assign card_pins      = st_r.pins;
    assign card_pins_oe_n = st_r.pins_oe_n;
    assign card_data_oe_n = st_r.data_oe_n;
    assign csc_flag       = st_r.csc_flag;
    assign card_irq_flag  = st_r.irq_flag;
    assign irq_out        = st_r.irq_out;
    assign irq_oe_n       = st_r.irq_oe_n;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_pd_release: assert property (
        power_down_bit |=> (card_pins_oe_n == 2'b11 && card_data_oe_n == 2'b11))
        else $error("card pins driven during power-down");

    a_pd_answer: assert property (
        (st_r.fsm == S_IDLE && req_valid && power_down_bit)
        |=> (rsp_done && st_r.fsm == S_IDLE))
        else $error("power-down access not answered or ran a card cycle");

    a_miss_idle: assert property (
        (st_r.fsm == S_IDLE && req_valid && !st_nxt.rsp_hit) |=> (rsp_done && !rsp_hit))
        else $error("missed access not answered as miss");

    a_strobe_length: assert property (
        (st_r.fsm == S_HOLD && $past(st_r.fsm) == S_STROBE) |-> st_r.strb_len >= st_r.want)
        else $error("card strobe shorter than wait-state setting");

    a_mem_low_bits: assert property (
        (st_r.fsm == S_SETUP && !st_r.is_io)
        |-> card_pins[st_r.sock].addr[11:0] == $past(req.addr[11:0]))
        else $error("card address low bits not taken from host");

    a_io_addr_high: assert property (
        (st_r.fsm == S_SETUP && st_r.is_io)
        |-> (card_pins[st_r.sock].addr[25:16] == 10'h000
             && card_pins[st_r.sock].addr[15:0] == $past(req.addr[15:0])))
        else $error("i/o card address not the host address");

    a_csc_set_wins: assert property (
        (csc_clear[0] && {card_sts[0].bvd1, card_sts[0].bvd2, card_sts[0].cd1_n,
                          card_sts[0].cd2_n} != st_r.prev_sts[0][3:0]) |=> csc_flag[0])
        else $error("status change lost against clear");

    a_pci_irq_float: assert property (
        !isa_mode[0] |=> (irq_out[0] == 1'b0))
        else $error("open-drain terminal drove high");

    a_card_irq_route: assert property (
        (irq_route[0] == 4'h1 && card_is_io[0] && !card_sts[0].rdy_bsy && isa_mode[0])
        |=> irq_out[0])
        else $error("card interrupt not routed to terminal");

    a_strobe_single: assert property (
        (st_r.fsm == S_STROBE) |-> !(card_pins[0].oe_n == 1'b0 && card_pins[1].oe_n == 1'b0))
        else $error("both sockets strobed at once");
endmodule
`default_nettype wire

// [testbench/card_socket.sv]
// card socket model: data from low address lines, card detect set by the bench
`timescale 1ns/1ps
`default_nettype none
module card_socket (
    // clock and pins from the mapper
    input  wire logic                        clk_sys,
    input  wire card_window_pkg::card_pins_t pins,
    input  wire logic                        pins_oe_n,
    // card side answers
    input  wire logic                        cd_n,
    output logic      [15:0]                 data,
    output card_window_pkg::card_sts_t       sts
);
    import card_window_pkg::*;
    logic [15:0] last_r = 16'h0000;
    // only low address lines decoded; an idle bus keeps changing
    assign data = (!pins_oe_n && !(pins.oe_n && pins.iord_n))
                  ? {~pins.addr[7:0], pins.addr[7:0]} : ~last_r;
    always @(posedge clk_sys) last_r <= data;
    // ready, battery good, never waits
    assign sts = '{1'b1, 1'b1, 1'b1, cd_n, cd_n, 1'b1};
endmodule
`default_nettype wire

// [testbench/tb.sv]
// self-checking bench for the card window mapper
`timescale 1ns/1ps
`default_nettype none
module tb;
    import card_window_pkg::*;
    logic clk_sys = 1'b0, reset = 1'b1, power_down_bit = 1'b0, cfg_we = 1'b0;
    logic req_valid = 1'b0, clr = 1'b0, cd_n = 1'b0, reg_n, ce2;
    logic [6:0] cfg_addr = 7'h00;
    logic [7:0] cfg_wdata = 8'h00, cfg_rdata;
    logic [9:0] isa_mode = 10'h000, irq_out;
    logic [1:0][3:0] csc_route = 8'h00;
    logic [3:0][3:0] io_ctrl = 16'h0000;
    logic req_ready, rsp_done, rsp_hit;
    logic [15:0] rsp_rdata;
    logic [25:0] ca;
    logic [1:0] card_pins_oe_n, csc_flag;
    host_req_t req = '0;
    card_pins_t [1:0] card_pins;
    wire logic [1:0][15:0] card_data_in;
    wire card_sts_t [1:0] card_sts;
    int err_count = 0, checks_done = 0, n;
    ////////////////////////////////////////////////////////////////
    card_window_mapper u_card_window_mapper (
        .clk_sys, .reset, .power_down_bit, .cfg_we, .cfg_addr, .cfg_wdata, .cfg_rdata,
        .io_ctrl, .req_valid, .req, .req_ready, .rsp_done, .rsp_hit, .rsp_rdata,
        .card_pins, .card_pins_oe_n, .card_data_oe_n(), .card_data_in, .card_sts,
        .card_is_io(2'b00), .card_reset_req(2'b00), .card_inpack_n(2'b11), .irq_route(8'h00),
        .csc_route, .isa_mode, .csc_clear({clr, clr}), .card_irq_clear({clr, clr}),
        .csc_flag, .card_irq_flag(), .irq_out, .irq_oe_n()
    );
    card_socket u_card_socket_a (.clk_sys, .pins(card_pins[0]), .pins_oe_n(card_pins_oe_n[0]),
        .cd_n, .data(card_data_in[0]), .sts(card_sts[0]));
    card_socket u_card_socket_b (.clk_sys, .pins(card_pins[1]), .pins_oe_n(card_pins_oe_n[1]),
        .cd_n(1'b0), .data(card_data_in[1]), .sts(card_sts[1]));
    ////////////////////////////////////////////////////////////////
    // clock at 4 ns
    initial forever #2 clk_sys = ~clk_sys;
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // config byte write; the caller drops the strobe after a burst
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        cfg_addr = a;
        cfg_wdata = d;
        cfg_we = 1'b1;
        @(posedge clk_sys);
        #1;
    endtask
    // one host read, memory or i/o; counts strobe cycles and keeps the pins seen in it
    task automatic do_req(input logic io, input logic [31:0] a);
        int i;
        req = '{io, 1'b0, a, 16'h0000};
        req_valid = 1'b1;
        n = 0;
        @(posedge clk_sys);
        #1 req_valid = 1'b0;
        for (i = 0; i < 400 && rsp_done !== 1'b1; i++) begin
            if (card_pins[0].oe_n === 1'b0 || card_pins[0].iord_n === 1'b0) begin
                n++;
                ca = card_pins[0].addr;
                reg_n = card_pins[0].reg_n;
                ce2 = card_pins[0].ce2_n;
            end
            @(posedge clk_sys);
            #1;
        end
        if (i == 400) begin
            chk("answer", 1'b0, 1'b1);
            report_and_stop;
        end
    endtask
    task automatic t_map;
        logic [7:0] b [6] = '{8'h10, 8'h80, 8'h20, 8'h00, 8'hf0, 8'hff};
        for (int i = 0; i < 6; i++) wr(7'(i), b[i]);
        cfg_we = 1'b0;
        do_req(1'b0, 32'h0001_5abc);
        chk("hit", rsp_hit, 1'b1);
        chk("strobe", n, 60);
        chk("addr", ca, 26'h000_5abc);
        chk("reg", reg_n, 1'b0);
        chk("ce2", ce2, 1'b0);
        chk("rdata", rsp_rdata, 16'h43bc);
        wr(7'h01, 8'h00);
        wr(7'h03, 8'h40);
        cfg_we = 1'b0;
        do_req(1'b0, 32'h0001_0000);
        chk("strobe8", n, 120);
        chk("ce2_8", ce2, 1'b1);
        $display("map test done");
    endtask
    task automatic t_miss;
        do_req(1'b0, 32'h0101_5abc);
        chk("page", rsp_hit, 1'b0);
        do_req(1'b0, 32'h0002_1000);
        chk("end", rsp_hit, 1'b0);
        wr(7'h00, 8'h00);
        cfg_we = 1'b0;
        do_req(1'b0, 32'h0000_5000);
        chk("low64k", rsp_hit, 1'b0);
        chk("nocyc", n, 0);
        $display("miss test done");
    endtask
    task automatic t_io;
        io_ctrl = 16'h0003;
        wr(7'h3c, 8'h00);
        wr(7'h3d, 8'h03);
        wr(7'h3e, 8'hff);
        wr(7'h3f, 8'h03);
        cfg_we = 1'b0;
        do_req(1'b1, 32'h0000_0345);
        chk("iohit", rsp_hit, 1'b1);
        chk("iostrobe", n, 60);
        chk("ioaddr", ca, 26'h000_0345);
        chk("iordata", rsp_rdata, 16'hba45);
        chk("ioce2", ce2, 1'b0);
        do_req(1'b1, 32'h0000_0400);
        chk("iomiss", rsp_hit, 1'b0);
        $display("i/o test done");
    endtask
    task automatic t_pd;
        power_down_bit = 1'b1;
        @(posedge clk_sys);
        #1 chk("float", card_pins_oe_n, 2'b11);
        do_req(1'b0, 32'h0001_5abc);
        chk("pdhit", rsp_hit, 1'b1);
        chk("pdcyc", n, 0);
        wr(7'h4d, 8'ha5);
        cfg_we = 1'b0;
        @(posedge clk_sys);
        #1 chk("pdcfg", cfg_rdata, 8'ha5);
        $display("power-down test done");
    endtask
    task automatic t_csc;
        csc_route[0] = 4'h1;
        isa_mode = 10'h001;
        chk("pre", csc_flag[0], 1'b0);
        cd_n = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 chk("csc", csc_flag[0], 1'b1);
        chk("irq", irq_out[0], 1'b1);
        clr = 1'b1;
        @(posedge clk_sys);
        #1 clr = 1'b0;
        @(posedge clk_sys);
        #1 chk("cleared", csc_flag[0], 1'b0);
        $display("status change test done");
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        #1 reset = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1 clr = 1'b1;
        @(posedge clk_sys);
        #1 clr = 1'b0;
        t_map;
        t_miss;
        t_io;
        t_pd;
        t_csc;
        report_and_stop;
    end
endmodule
`default_nettype wire
